/* File: owct_pkg.sv */
// package: option word layout, reset values and cycle timing constants for the loader
package owct_pkg;
  localparam int WORD_W = 13;
  localparam int OPC_W = 6;
  localparam int POS_CLS = 8;
  localparam int POS_WDB = 7;
  localparam int POS_XRS = 5;
  localparam int POS_CST = 4;
  localparam int POS_DPS = 3;
  localparam int POS_CPF_HI = 2;
  localparam int POS_CPF_LO = 0;
  localparam logic [2:0] CPF_OPEN = 3'h7;
  localparam logic [12:0] OPT_RST = 13'h1_FFF;
  localparam logic [12:0] CID_RST = 13'h0_000;
  localparam logic [12:0] RSVD_MASK = 13'h1_E40;
  localparam logic [2:0] PERIODS_SHORT = 3'h2;
  localparam logic [2:0] PERIODS_LONG = 3'h4;
  localparam logic [5:0] PC_REG_ADDR = 6'h02;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef struct packed {
    logic cycle_length_select;
    logic watchdog_disable_bit;
    logic crystal_range_select;
    logic clock_source_type_select;
    logic drive_power_select;
    logic [2:0] code_protect_field;
  } owct_opt_t;

  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic [2:0] bit_sel;
    logic [5:0] reg_addr;
    logic [9:0] literal;
  } owct_dec_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } owct_state_t;
endpackage

/* File: owct_top.sv */
// option word latch, instruction decode split and instruction-cycle timing
`timescale 1ns/10ps
module owct_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PRG_VALID_I,
  input wire logic PRG_WORD_SEL_I,
  input wire logic [owct_pkg::WORD_W-1:0] PRG_DATA_I,
  input wire logic INSTR_VALID_I,
  input wire logic [owct_pkg::WORD_W-1:0] INSTR_I,
  input wire logic SKIP_TRUE_I,
  output logic INSTR_READY_O,
  output owct_pkg::owct_opt_t OPT_O,
  output logic [owct_pkg::WORD_W-1:0] CUSTOMER_ID_O,
  output logic WATCHDOG_EN_O,
  output logic XTAL_HIGH_RANGE_O,
  output logic CODE_PROTECT_O,
  output logic RSVD_BITS_OK_O,
  output logic CYCLE_TICK_O,
  output logic TIMER_TICK_O,
  output owct_pkg::owct_dec_t DEC_O,
  output logic [7:0] BIT_MASK_O,
  output logic [1:0] INSTR_CYCLES_O,
  output logic RUNNING_O
);
  import owct_pkg::*;

  logic [WORD_W-1:0] opt_word;
  logic [WORD_W-1:0] cust_word;
  owct_opt_t opt_live;
  owct_state_t state;
  owct_state_t next_state;
  logic [1:0] osc_cnt;
  logic [2:0] periods;
  logic [1:0] cyc_left;
  logic busy;
  logic instr_take;
  logic prg_open;
  logic div_wrap;

  // bit b of a register, used by bit set/clear/test
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // writes into the program counter register change flow, so need the extra cycle
  function automatic logic writes_pc(input logic [WORD_W-1:0] w);
    logic r_dest;
    r_dest = 1'b0;
    if (w[5:0] == PC_REG_ADDR) begin
      case (w[12:10])
        3'b000,
        3'b001: begin
          // register group: move, clear and every odd sub-op that lands in the register
          if (w[10:6] == 5'h01 || w[10:6] == 5'h03) begin
            r_dest = 1'b1;
          end else if (w[10:6] >= 5'h04 && w[6]) begin
            r_dest = 1'b1;
          end
        end
        3'b010: begin
          // bit clear and bit set aimed at the program counter
          r_dest = 1'b1;
        end
        default: begin
          r_dest = 1'b0;
        end
      endcase
    end
    writes_pc = r_dest;
  endfunction

  // flow changes: returns, call and jump
  function automatic logic is_branch(input logic [WORD_W-1:0] w);
    logic br;
    br = 1'b0;
    case (w[12:10])
      3'b000: begin
        // the two return forms sit in the control group
        br = (w == 13'h0_012) || (w == 13'h0_013);
      end
      3'b100,
      3'b101: begin
        // call and jump carry a 10-bit target
        br = 1'b1;
      end
      3'b111: begin
        // top literal group is treated as return with literal
        br = 1'b1;
      end
      default: begin
        br = 1'b0;
      end
    endcase
    is_branch = br;
  endfunction

  // skip family; two cycles when the tested condition is true, or when the result is written to the program counter
  function automatic logic is_skip(input logic [WORD_W-1:0] w);
    logic sk;
    sk = 1'b0;
    case (w[12:10])
      3'b000,
      3'b001: begin
        // decrement or increment, then skip if zero
        sk = (w[12:7] == 6'h0B) || (w[12:7] == 6'h0F);
      end
      3'b011: begin
        // bit test, skip on clear or on set
        sk = 1'b1;
      end
      default: begin
        sk = 1'b0;
      end
    endcase
    is_skip = sk;
  endfunction

  // cycle class of an accepted instruction, shared by the count output and the busy counter
  function automatic logic [1:0] cycles_for(input logic [WORD_W-1:0] w, input logic skip);
    logic [1:0] n;
    n = CYC_ONE;
    if (writes_pc(w)) begin
      n = CYC_TWO;
    end else if (is_branch(w) || (is_skip(w) && skip)) begin
      n = CYC_TWO;
    end
    cycles_for = n;
  endfunction

  // writes are open only until the run state; running code has no path here
  assign prg_open = PRG_VALID_I && (state != ST_RUN);

  // programmer-only path: no instruction reaches these words
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      opt_word <= OPT_RST;
    end else if (prg_open && !PRG_WORD_SEL_I) begin
      opt_word <= PRG_DATA_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cust_word <= CID_RST;
    end else if (prg_open && PRG_WORD_SEL_I) begin
      cust_word <= PRG_DATA_I;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // fields frozen on entry to run; programmer writes after that are refused
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      opt_live <= owct_opt_t'(8'hFF);
    end else if (state == ST_LOAD) begin
      opt_live.cycle_length_select <= opt_word[POS_CLS];
      opt_live.watchdog_disable_bit <= opt_word[POS_WDB];
      opt_live.crystal_range_select <= opt_word[POS_XRS];
      opt_live.clock_source_type_select <= opt_word[POS_CST];
      opt_live.drive_power_select <= opt_word[POS_DPS];
      opt_live.code_protect_field <= opt_word[POS_CPF_HI:POS_CPF_LO];
    end
  end

  // identifier word is latched at the same point as the options
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CUSTOMER_ID_O <= CID_RST;
    end else if (state == ST_LOAD) begin
      CUSTOMER_ID_O <= cust_word;
    end
  end

  assign OPT_O = opt_live;
  assign RUNNING_O = (state == ST_RUN);
  assign WATCHDOG_EN_O = ~opt_live.watchdog_disable_bit;
  // range bit ignored in RC mode; programmer is expected to write it zero there
  assign XTAL_HIGH_RANGE_O = opt_live.clock_source_type_select
                           & opt_live.crystal_range_select;
  assign CODE_PROTECT_O = (opt_live.code_protect_field != CPF_OPEN);
  // flags a programmer that broke the reserved-ones convention
  assign RSVD_BITS_OK_O = ((opt_word & RSVD_MASK) == RSVD_MASK);

  assign periods = opt_live.cycle_length_select ? PERIODS_LONG : PERIODS_SHORT;

  // last oscillator period of one instruction cycle
  assign div_wrap = ({1'b0, osc_cnt} == periods - 3'h1);

  // one oscillator period per CLK_I edge; divider runs only while the program runs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_cnt <= 2'h0;
    end else if (state == ST_RUN && !div_wrap) begin
      osc_cnt <= osc_cnt + 2'h1;
    end else begin
      osc_cnt <= 2'h0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CYCLE_TICK_O <= 1'b0;
    end else if (state == ST_RUN && div_wrap) begin
      CYCLE_TICK_O <= 1'b1;
    end else begin
      CYCLE_TICK_O <= 1'b0;
    end
  end

  // timer clock comes from the same divider, so it follows the cycle length
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TIMER_TICK_O <= 1'b0;
    end else if (state == ST_RUN && div_wrap) begin
      TIMER_TICK_O <= 1'b1;
    end else begin
      TIMER_TICK_O <= 1'b0;
    end
  end

  assign busy = (cyc_left != 2'h0);
  assign INSTR_READY_O = RUNNING_O & ~busy;
  assign instr_take = INSTR_VALID_I & INSTR_READY_O;

  // decode split, captured when an instruction is accepted
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DEC_O <= '0;
    end else if (instr_take) begin
      DEC_O.opcode <= INSTR_I[12:7];
      // bit number sits just above the register field
      DEC_O.bit_sel <= INSTR_I[8:6];
      DEC_O.reg_addr <= INSTR_I[5:0];
      DEC_O.literal <= INSTR_I[9:0];
    end
  end

  // one-hot bit select for the set, clear and test datapath
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BIT_MASK_O <= 8'h00;
    end else if (instr_take) begin
      BIT_MASK_O <= bit_mask(INSTR_I[8:6]);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      INSTR_CYCLES_O <= 2'h0;
    end else if (instr_take) begin
      INSTR_CYCLES_O <= cycles_for(INSTR_I, SKIP_TRUE_I);
    end
  end

  // instruction stays in progress until its cycles have ticked away
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cyc_left <= 2'h0;
    end else if (instr_take) begin
      cyc_left <= cycles_for(INSTR_I, SKIP_TRUE_I);
    end else if (busy && CYCLE_TICK_O) begin
      cyc_left <= cyc_left - 2'h1;
    end
  end
endmodule // owct_top

/* File: owct_properties.sv */
// checker: option latch, decode and cycle timing properties
`timescale 1ns/10ps
module owct_properties (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic INSTR_VALID_I,
  input wire logic [owct_pkg::WORD_W-1:0] INSTR_I,
  input wire logic INSTR_READY_O,
  input wire owct_pkg::owct_opt_t OPT_O,
  input wire logic [owct_pkg::WORD_W-1:0] CUSTOMER_ID_O,
  input wire logic WATCHDOG_EN_O,
  input wire logic XTAL_HIGH_RANGE_O,
  input wire logic CODE_PROTECT_O,
  input wire logic CYCLE_TICK_O,
  input wire logic TIMER_TICK_O,
  input wire owct_pkg::owct_dec_t DEC_O,
  input wire logic [7:0] BIT_MASK_O,
  input wire logic [1:0] INSTR_CYCLES_O,
  input wire logic RUNNING_O
);
  import owct_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire take = INSTR_VALID_I && INSTR_READY_O;
  sequence gap_short;
    !CYCLE_TICK_O ##1 CYCLE_TICK_O;
  endsequence
  sequence gap_long;
    !CYCLE_TICK_O [*3] ##1 CYCLE_TICK_O;
  endsequence
  tick_short_a: assert property (CYCLE_TICK_O && !OPT_O.cycle_length_select |=> gap_short)
    else $error("short cycle spacing wrong");
  tick_long_a: assert property (CYCLE_TICK_O && OPT_O.cycle_length_select |=> gap_long)
    else $error("long cycle spacing wrong");
  timer_tick_a: assert property (TIMER_TICK_O == CYCLE_TICK_O)
    else $error("timer clock differs from cycle");
  wdog_enable_a: assert property (WATCHDOG_EN_O == !OPT_O.watchdog_disable_bit)
    else $error("watchdog enable wrong");
  xtal_range_a: assert property (XTAL_HIGH_RANGE_O == (OPT_O.clock_source_type_select && OPT_O.crystal_range_select))
    else $error("crystal range wrong");
  code_protect_a: assert property (CODE_PROTECT_O == (OPT_O.code_protect_field != CPF_OPEN))
    else $error("protection wrong");
  opt_hold_a: assert property ($past(RUNNING_O) |-> $stable(OPT_O) && $stable(CUSTOMER_ID_O))
    else $error("options changed while running");
  decode_split_a: assert property (take |=> DEC_O.reg_addr == $past(INSTR_I[5:0]) && BIT_MASK_O == 8'h01 << $past(INSTR_I[8:6]))
    else $error("decode fields wrong");
  ret_two_a: assert property (take && INSTR_I == 13'h0_012 |=> INSTR_CYCLES_O == CYC_TWO && !INSTR_READY_O)
    else $error("return not two cycles");
  sequence busy_two;
    !INSTR_READY_O && INSTR_CYCLES_O == CYC_TWO;
  endsequence
  pc_write_two_a: assert property (take && INSTR_I == 13'h0_042 |=> busy_two)
    else $error("pc write not two cycles");
  call_two_a: assert property (take && INSTR_I[12:10] == 3'b100 |=> busy_two)
    else $error("call not two cycles");
endmodule // owct_properties
bind owct_top owct_properties u_props (.CLK_I(CLK_I), .RST_I(RST_I), .INSTR_VALID_I(INSTR_VALID_I),
  .INSTR_I(INSTR_I), .INSTR_READY_O(INSTR_READY_O), .OPT_O(OPT_O), .CUSTOMER_ID_O(CUSTOMER_ID_O),
  .WATCHDOG_EN_O(WATCHDOG_EN_O), .XTAL_HIGH_RANGE_O(XTAL_HIGH_RANGE_O),
  .CODE_PROTECT_O(CODE_PROTECT_O), .CYCLE_TICK_O(CYCLE_TICK_O), .TIMER_TICK_O(TIMER_TICK_O),
  .DEC_O(DEC_O), .BIT_MASK_O(BIT_MASK_O), .INSTR_CYCLES_O(INSTR_CYCLES_O),
  .RUNNING_O(RUNNING_O));

/* File: owct_prog_model.sv */
// programmer model: writes the one-time option and identifier words
`timescale 1ns/10ps
module owct_prog_model (
  input wire logic clk_i,
  output logic valid_o = 1'b0,
  output logic sel_o = 1'b0,
  output logic [owct_pkg::WORD_W-1:0] data_o = 13'h0_000
);
  import owct_pkg::*;
  logic [WORD_W-1:0] w;
  // caller sits on a rising edge; request lasts exactly one edge
  task automatic write(input logic sel, input logic [WORD_W-1:0] d);
    w = sel ? d : d | RSVD_MASK;
    if (!sel && !d[POS_CST]) w[POS_XRS] = 1'b0;
    valid_o <= 1'b1;
    sel_o <= sel;
    data_o <= w;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // released data must not look like the last word
    data_o <= ~w;
  endtask
endmodule // owct_prog_model

/* File: tb.sv */
// testbench: option latch, decode and cycle timing scenarios
`timescale 1ns/10ps
module tb;
  import owct_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic PRG_VALID_I, PRG_WORD_SEL_I, INSTR_READY_O, WATCHDOG_EN_O, XTAL_HIGH_RANGE_O;
  logic CODE_PROTECT_O, RSVD_BITS_OK_O, CYCLE_TICK_O, TIMER_TICK_O, RUNNING_O;
  logic INSTR_VALID_I = 1'b0;
  logic SKIP_TRUE_I = 1'b0;
  logic [WORD_W-1:0] INSTR_I = 13'h0_000;
  logic [WORD_W-1:0] PRG_DATA_I, CUSTOMER_ID_O;
  owct_opt_t OPT_O;
  owct_dec_t DEC_O;
  logic [7:0] BIT_MASK_O;
  logic [1:0] INSTR_CYCLES_O;
  logic [12:0] ops [8] = '{13'h0_000, 13'h0_012, 13'h0_042, 13'h0_043,
                          13'h0_B02, 13'h1_000, 13'h0_E02, 13'h0_E02};
  logic [7:0] two = 8'hB6;
  int mismatches = 0;
  int checked = 0;
  always #2.5 CLK_I = ~CLK_I;
  owct_prog_model prog (.clk_i(CLK_I), .valid_o(PRG_VALID_I), .sel_o(PRG_WORD_SEL_I),
    .data_o(PRG_DATA_I));
  owct_top dut (.*);
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // words can only be written between reset release and the run state
  task automatic boot(input logic sel, input logic [12:0] d);
    @(posedge CLK_I);
    RST_I <= 1'b1;
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
    prog.write(sel, d);
    repeat (3) @(posedge CLK_I);
    #1;
    check("running", RUNNING_O, 1'b1);
  endtask
  task automatic ticks(input logic [12:0] exp);
    logic [12:0] c;
    logic [12:0] t;
    c = 13'h0_000;
    t = 13'h0_000;
    repeat (8) begin
      @(posedge CLK_I);
      #1;
      if (CYCLE_TICK_O === 1'b1) c++;
      if (TIMER_TICK_O === 1'b1) t++;
    end
    check("ticks", c, exp);
    check("timer ticks", t, exp);
  endtask
  task automatic exec(input int i);
    @(posedge CLK_I);
    INSTR_VALID_I <= 1'b1;
    INSTR_I <= ops[i];
    SKIP_TRUE_I <= (i == 7);
    @(posedge CLK_I);
    INSTR_VALID_I <= 1'b0;
    #1;
    check("busy", INSTR_READY_O, 1'b0);
    check("cycles", INSTR_CYCLES_O, two[i] ? CYC_TWO : CYC_ONE);
    check("mask", BIT_MASK_O, 8'h01 << ops[i][8:6]);
    check("bit sel", DEC_O.bit_sel, ops[i][8:6]);
    check("reg", DEC_O.reg_addr, ops[i][5:0]);
    check("opcode", DEC_O.opcode, ops[i][12:7]);
    repeat (20) begin
      if (INSTR_READY_O !== 1'b1) begin
        @(posedge CLK_I);
        #1;
      end
    end
    check("ready", INSTR_READY_O, 1'b1);
  endtask
  initial begin
    boot(1'b0, 13'h0_13A);
    check("opt", OPT_O, 8'hBA);
    check("wdog", WATCHDOG_EN_O, 1'b1);
    check("xtal", XTAL_HIGH_RANGE_O, 1'b1);
    check("protect", CODE_PROTECT_O, 1'b1);
    check("reserved", RSVD_BITS_OK_O, 1'b1);
    @(posedge CLK_I);
    prog.write(1'b0, 13'h0_000);
    #1;
    check("refused", OPT_O, 8'hBA);
    ticks(13'h0_002);
    for (int i = 0; i < 8; i++) exec(i);
    boot(1'b1, 13'h1_5A3);
    check("id", CUSTOMER_ID_O, 13'h1_5A3);
    check("opt dflt", OPT_O, 8'hFF);
    check("protect", CODE_PROTECT_O, 1'b0);
    boot(1'b0, 13'h0_018);
    check("opt lo xtal", OPT_O, 8'h18);
    check("xtal", XTAL_HIGH_RANGE_O, 1'b0);
    check("wdog", WATCHDOG_EN_O, 1'b1);
    check("protect", CODE_PROTECT_O, 1'b1);
    boot(1'b0, 13'h0_0A7);
    check("opt rc", OPT_O, 8'h47);
    check("wdog", WATCHDOG_EN_O, 1'b0);
    check("xtal", XTAL_HIGH_RANGE_O, 1'b0);
    ticks(13'h0_004);
    exec(0);
    wrap_up();
  end
  initial begin
    #10000;
    mismatches++;
    wrap_up();
  end
endmodule // tb
